//--- hw/rsc_cfg.svh
// constants for the reset and stop recovery controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_DLY_SHORT      13'd66
`define RSC_DLY_XTAL       13'd5000
`define RSC_PIN_TRIG_CYC   3'd4
`define RSC_VECTOR_HI_ADDR 16'h0002
`define RSC_VECTOR_LO_ADDR 16'h0003
`define RSC_CAUSE_POR_BIT  7
`define RSC_CAUSE_STOP_BIT 6
`define RSC_CAUSE_WDT_BIT  5
`define RSC_CAUSE_EXT_BIT  4
`define RSC_CAUSE_LVD_BIT  0
`endif

//--- hw/rsc_pkg.sv
// types shared by the reset and stop recovery controller
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_RUN,
        RSC_HOLD,
        RSC_PIN_WAIT
    } rsc_state_e;
    typedef enum logic [1:0] {
        RSC_KIND_NONE,
        RSC_KIND_SYS,
        RSC_KIND_SMR
    } rsc_kind_e;
endpackage

//--- hw/rsc_pin_filter.sv
// reset pin synchroniser and low-width filter
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_pin_filter (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // pin level
    input  wire logic pin_in,
    // filtered results
    output logic      pin_low_sync,
    output logic      pin_trig
);
    logic       sync1_q;
    logic       sync2_q;
    logic [2:0] low_cnt_q;

    // two stages; first is read only by the second
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // saturating count of consecutive low cycles
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            low_cnt_q <= 3'h0;
        end else if (sync2_q) begin
            low_cnt_q <= 3'h0;
        end else if (low_cnt_q != `RSC_PIN_TRIG_CYC) begin
            low_cnt_q <= low_cnt_q + 3'h1;
        end
    end

    assign pin_low_sync = ~sync2_q;
    // fires on the fourth consecutive low sample, so a three cycle pulse never triggers
    assign pin_trig = (low_cnt_q == `RSC_PIN_TRIG_CYC - 3'd1) & ~sync2_q;
endmodule

//--- hw/rsc_delay_cnt.sv
// shared reset delay counter on the internal oscillator
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_delay_cnt #(
    parameter int W = 13
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // control
    input  wire logic         start,
    input  wire logic         osc_tick,
    input  wire logic         xtal_en,
    // status
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic         run_q;
    logic [W-1:0] term;

    assign term = xtal_en ? W'(`RSC_DLY_XTAL) : W'(`RSC_DLY_SHORT);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            // power-up delay runs straight out of reset
            cnt_q <= '0;
            run_q <= 1'b1;
        end else if (start) begin
            cnt_q <= '0;
            run_q <= 1'b1;
        end else if (run_q && osc_tick) begin
            if (cnt_q == term - W'(1)) begin
                run_q <= 1'b0;
            end
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done = ~run_q & ~start;
endmodule

//--- hw/rsc_reset_ctrl.sv
// reset, stop-mode recovery and low-voltage controller
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_reset_ctrl #(
    parameter int NGPIO = 8,
    parameter int DW    = 13
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // analog status and options
    input  wire logic             brownout_low,
    input  wire logic             lvd_low,
    input  wire logic             brownout_detector_en,
    input  wire logic             brownout_in_stop_enable,
    input  wire logic             watchdog_reset_select,
    input  wire logic             xtal_en,
    input  wire logic             osc_tick,
    // sources
    input  wire logic             wdt_timeout,
    input  wire logic             debugger_rst_set,
    input  wire logic             debug_pin_in,
    input  wire logic             stop_mode,
    input  wire logic             gie,
    input  wire logic [NGPIO-1:0] gpio_in,
    input  wire logic [NGPIO-1:0] smr_src_en,
    input  wire logic             gpio_rst_drive_en,
    // reset pin, open drain
    input  wire logic             rst_pin_in,
    output logic                  rst_pin_out,
    output logic                  rst_pin_oe,
    // cause register read
    input  wire logic             cause_rd,
    output logic [7:0]            reset_cause_register,
    // results
    output logic                  sys_rst,
    output logic                  cpu_rst,
    output logic                  debugger_rst_clr,
    output logic                  ctl_regs_rst,
    output logic                  wdt_osc_regs_rst,
    output logic                  internal_osc_sel,
    output logic [15:0]           vector_hi_addr,
    output logic [15:0]           vector_lo_addr,
    output logic                  wdt_irq,
    output logic                  lvd_irq_req,
    output logic                  brownout_active,
    output logic                  port_input_en,
    output logic [NGPIO-1:0]      port_input_data
);
    logic                 pin_low;
    logic                 pin_trig;
    logic                 dly_done;
    logic                 start;
    logic                 dly_start;
    logic                 bo_low;
    logic                 wdt_sys;
    logic                 smr_req;
    logic                 sys_req;
    logic [NGPIO-1:0]     gpio_q;
    logic [NGPIO-1:0]     gpio_chg;
    logic                 por_q;
    logic                 stop_q;
    logic                 wdt_q;
    logic                 ext_q;
    logic                 wdt_irq_pend_q;
    logic                 osc_sel_q;
    logic                 dbg_q;
    rsc_pkg::rsc_state_e  st_q;
    rsc_pkg::rsc_kind_e   kind_q;

    rsc_pin_filter u_pin (
        .core_clk     (core_clk),
        .reset        (reset),
        .pin_in       (rst_pin_in),
        .pin_low_sync (pin_low),
        .pin_trig     (pin_trig)
    );

    rsc_delay_cnt #(.W(DW)) u_dly (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (dly_start),
        .osc_tick (osc_tick),
        .xtal_en  (xtal_en),
        .done     (dly_done)
    );

    assign brownout_active = brownout_detector_en &
                             (~stop_mode | brownout_in_stop_enable);
    assign bo_low  = brownout_active & brownout_low;
    assign wdt_sys = wdt_timeout & ~stop_mode & watchdog_reset_select;
    assign gpio_chg = (gpio_in ^ gpio_q) & smr_src_en;
    assign smr_req = stop_mode & ((|gpio_chg) | wdt_timeout);
    // pin and debug pin outrank recovery in stop
    assign sys_req = bo_low | wdt_sys | pin_trig | debugger_rst_set |
                     (stop_mode & ~debug_pin_in);
    assign start = (sys_req | smr_req) & (st_q == rsc_pkg::RSC_RUN);
    // delay counts from supply recovery, not from the drop
    assign dly_start = start | bo_low;

    // previous gpio level for edge detection
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            gpio_q <= '0;
        end else begin
            gpio_q <= gpio_in;
        end
    end

    // sequencer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q   <= rsc_pkg::RSC_HOLD;
            kind_q <= rsc_pkg::RSC_KIND_SYS;
        end else begin
            unique case (st_q)
                rsc_pkg::RSC_RUN: begin
                    if (sys_req) begin
                        st_q   <= rsc_pkg::RSC_HOLD;
                        kind_q <= rsc_pkg::RSC_KIND_SYS;
                    end else if (smr_req) begin
                        st_q   <= rsc_pkg::RSC_HOLD;
                        kind_q <= rsc_pkg::RSC_KIND_SMR;
                    end
                end
                rsc_pkg::RSC_HOLD: begin
                    // brown-out keeps the delay from starting
                    if (bo_low) begin
                        st_q <= rsc_pkg::RSC_HOLD;
                    end else if (dly_done) begin
                        if (pin_low && kind_q == rsc_pkg::RSC_KIND_SYS) begin
                            st_q <= rsc_pkg::RSC_PIN_WAIT;
                        end else begin
                            st_q   <= rsc_pkg::RSC_RUN;
                            kind_q <= rsc_pkg::RSC_KIND_NONE;
                        end
                    end
                end
                rsc_pkg::RSC_PIN_WAIT: begin
                    if (bo_low) begin
                        st_q <= rsc_pkg::RSC_HOLD;
                    end else if (!pin_low) begin
                        st_q   <= rsc_pkg::RSC_RUN;
                        kind_q <= rsc_pkg::RSC_KIND_NONE;
                    end
                end
            endcase
        end
    end

    // brown-out level of the previous cycle, for the delay restart check
    logic bo_seen_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bo_seen_q <= 1'b0;
        end else begin
            bo_seen_q <= bo_low;
        end
    end

    // cause flags; event set wins over read clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            por_q  <= 1'b1;
            stop_q <= 1'b0;
            wdt_q  <= 1'b0;
            ext_q  <= 1'b0;
        end else if (start && sys_req) begin
            por_q  <= ~wdt_sys & ~pin_trig;
            stop_q <= 1'b0;
            wdt_q  <= wdt_sys & ~pin_trig;
            ext_q  <= pin_trig;
        end else if (start) begin
            por_q  <= 1'b0;
            stop_q <= 1'b1;
            wdt_q  <= wdt_timeout;
            ext_q  <= 1'b0;
        end else if (cause_rd) begin
            por_q  <= 1'b0;
            stop_q <= 1'b0;
            wdt_q  <= 1'b0;
            ext_q  <= 1'b0;
        end
    end

    assign reset_cause_register = {por_q, stop_q, wdt_q, ext_q, 3'h0,
                                   brownout_active & lvd_low};
    assign lvd_irq_req = brownout_active & lvd_low;

    // watchdog interrupt, deferred past recovery
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wdt_irq_pend_q <= 1'b0;
        end else if (wdt_timeout && !watchdog_reset_select) begin
            wdt_irq_pend_q <= 1'b1;
        end else if (st_q == rsc_pkg::RSC_RUN) begin
            wdt_irq_pend_q <= 1'b0;
        end
    end
    assign wdt_irq = wdt_irq_pend_q & gie & (st_q == rsc_pkg::RSC_RUN);

    // oscillator selection after any recovery
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            osc_sel_q <= 1'b1;
        end else if (st_q != rsc_pkg::RSC_RUN) begin
            osc_sel_q <= 1'b1;
        end else begin
            osc_sel_q <= 1'b0;
        end
    end
    assign internal_osc_sel = osc_sel_q;

    // debugger control bit cleared during the reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dbg_q <= 1'b0;
        end else begin
            dbg_q <= (kind_q == rsc_pkg::RSC_KIND_SYS) &
                     (st_q != rsc_pkg::RSC_RUN);
        end
    end
    assign debugger_rst_clr = dbg_q;

    assign cpu_rst = (st_q != rsc_pkg::RSC_RUN);
    assign sys_rst = (kind_q == rsc_pkg::RSC_KIND_SYS);
    // recovery touches only watchdog and oscillator control
    assign ctl_regs_rst = sys_rst;
    assign wdt_osc_regs_rst = cpu_rst;
    assign vector_hi_addr = `RSC_VECTOR_HI_ADDR;
    assign vector_lo_addr = `RSC_VECTOR_LO_ADDR;

    // open drain: only ever drives low
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = (sys_rst & (st_q == rsc_pkg::RSC_HOLD)) |
                         gpio_rst_drive_en;

    // port inputs frozen during stop and recovery
    assign port_input_en = ~stop_mode & ~cpu_rst;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            port_input_data <= '0;
        end else if (port_input_en) begin
            port_input_data <= gpio_in;
        end
    end

    a_hold_cpu: assert property (@(posedge core_clk) disable iff (reset)
        bo_low |=> cpu_rst) else $error("brown-out did not hold reset");
    a_pin_hold: assert property (@(posedge core_clk) disable iff (reset)
        (pin_low && st_q == rsc_pkg::RSC_PIN_WAIT) |=> cpu_rst)
        else $error("released while pin low");
    a_pin_flag: assert property (@(posedge core_clk) disable iff (reset)
        (start && pin_trig) |=> ext_q) else $error("pin flag missing");
    a_stop_flag: assert property (@(posedge core_clk) disable iff (reset)
        (start && !sys_req) |=> stop_q) else $error("stop flag missing");
    a_read_clr: assert property (@(posedge core_clk) disable iff (reset)
        (cause_rd && !start) |=> reset_cause_register[7:4] == 4'h0)
        else $error("read did not clear flags");
    a_lvd_live: assert property (@(posedge core_clk) disable iff (reset)
        reset_cause_register[0] == (lvd_low & brownout_active))
        else $error("lvd flag not live");
    a_od_drive: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == rsc_pkg::RSC_HOLD && sys_rst) |-> (rst_pin_oe && !rst_pin_out))
        else $error("pin not driven low");
    a_wdt_int: assert property (@(posedge core_clk) disable iff (reset)
        (wdt_timeout && !watchdog_reset_select && !stop_mode &&
         st_q == rsc_pkg::RSC_RUN && !sys_req) |=> !cpu_rst)
        else $error("watchdog interrupt mode reset");
    a_bo_restart: assert property (@(posedge core_clk) disable iff (reset)
        (bo_seen_q && !bo_low) |-> !dly_done)
        else $error("delay not restarted after brown-out");
    a_smr_kept: assert property (@(posedge core_clk) disable iff (reset)
        (start && !sys_req) |=> (cpu_rst && !ctl_regs_rst))
        else $error("recovery reset control registers");
endmodule

//--- test/rsc_board_model.sv
// board side of the shared open-drain reset line
`timescale 1ns/1ps
module rsc_board_model (
    // device side of the pin
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_out,
    // other board parts pulling the line low
    input  wire logic board_pull_low,
    // resolved line level
    output logic      rst_line
);
    // pull-up wins only when nobody drives low
    assign rst_line = ((rst_pin_oe && !rst_pin_out) || board_pull_low)
                      ? 1'b0 : 1'b1;
endmodule

//--- test/rsc_reset_ctrl_bench.sv
// sequence tests for the reset and stop recovery controller
`timescale 1ns/1ps
module rsc_reset_ctrl_bench;
    logic       core_clk, reset, bo_low, lvd_low, bo_en, bo_stop, wd_sel;
    logic       xtal_en, osc_tick, wdt_to, dbg_set, dbg_pin, stop_mode, gie;
    logic [7:0] gpio_in, smr_en;
    logic       gpio_drv, pull_low, rst_line, pin_out, pin_oe, cause_rd;
    logic [7:0] cause, pdata;
    logic       sys_rst, cpu_rst, dbg_clr, ctl_rst, wo_rst, osc_sel;
    logic [15:0] vhi, vlo;
    logic       wdt_irq, lvd_irq, bo_act, pin_en;
    int         mismatches, checks_done;

    rsc_reset_ctrl #(.NGPIO(8), .DW(13)) u_dut (
        .core_clk(core_clk), .reset(reset), .brownout_low(bo_low),
        .lvd_low(lvd_low), .brownout_detector_en(bo_en),
        .brownout_in_stop_enable(bo_stop), .watchdog_reset_select(wd_sel),
        .xtal_en(xtal_en), .osc_tick(osc_tick), .wdt_timeout(wdt_to),
        .debugger_rst_set(dbg_set), .debug_pin_in(dbg_pin),
        .stop_mode(stop_mode), .gie(gie), .gpio_in(gpio_in),
        .smr_src_en(smr_en), .gpio_rst_drive_en(gpio_drv),
        .rst_pin_in(rst_line), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe),
        .cause_rd(cause_rd), .reset_cause_register(cause),
        .sys_rst(sys_rst), .cpu_rst(cpu_rst), .debugger_rst_clr(dbg_clr),
        .ctl_regs_rst(ctl_rst), .wdt_osc_regs_rst(wo_rst),
        .internal_osc_sel(osc_sel), .vector_hi_addr(vhi),
        .vector_lo_addr(vlo), .wdt_irq(wdt_irq), .lvd_irq_req(lvd_irq),
        .brownout_active(bo_act), .port_input_en(pin_en),
        .port_input_data(pdata)
    );
    rsc_board_model u_board (
        .rst_pin_oe(pin_oe), .rst_pin_out(pin_out),
        .board_pull_low(pull_low), .rst_line(rst_line)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // one oscillator tick every second core cycle
    always @(posedge core_clk) osc_tick <= ~osc_tick;

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // counts oscillator ticks until the cpu leaves reset
    task automatic wait_rel(input int lo, input int hi);
        int n;
        int c;
        n = 0;
        c = 0;
        while (cpu_rst !== 1'b0 && c < 12000) begin
            if (osc_tick === 1'b1) n++;
            step(1);
            c++;
        end
        chk("release in range", 16'h1, 16'((n >= lo) && (n <= hi)));
    endtask
    task automatic rd_cause(input logic [3:0] exp);
        chk("cause flags", {12'h0, exp}, {12'h0, cause[7:4]});
        cause_rd = 1'b1;
        step(1);
        cause_rd = 1'b0;
        step(1);
    endtask
    task automatic wdt_pulse();
        wdt_to = 1'b1;
        step(1);
        wdt_to = 1'b0;
        step(1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    initial begin
        {bo_low, lvd_low, xtal_en, wdt_to, dbg_set, stop_mode} = '0;
        {gpio_drv, pull_low, cause_rd, osc_tick} = '0;
        {bo_en, bo_stop, wd_sel, dbg_pin, gie} = '1;
        gpio_in = 8'h00;
        smr_en = 8'h01;
        mismatches = 0;
        checks_done = 0;
        reset = 1'b1;
        step(2);
        reset = 1'b0;
        chk("oe at power-up", 16'h1, {15'h0, pin_oe});
        chk("line low at power-up", 16'h0, {15'h0, rst_line});
        wait_rel(64, 70);
        chk("oe after delay", 16'h0, {15'h0, pin_oe});
        chk("vector hi", 16'h0002, vhi);
        chk("vector lo", 16'h0003, vlo);
        rd_cause(4'b1000);
        rd_cause(4'b0000);
        // short pin pulse, then a long one held past the delay
        pull_low = 1'b1;
        step(2);
        pull_low = 1'b0;
        step(8);
        chk("short pulse", 16'h0, {15'h0, cpu_rst});
        pull_low = 1'b1;
        step(8);
        chk("pin reset", 16'h1, {15'h0, cpu_rst});
        chk("pin driven", 16'h1, {15'h0, pin_oe});
        step(250);
        chk("held by pin", 16'h1, {15'h0, cpu_rst});
        pull_low = 1'b0;
        step(6);
        chk("pin release", 16'h0, {15'h0, cpu_rst});
        rd_cause(4'b0001);
        // watchdog as reset, then as interrupt
        wdt_pulse();
        chk("wdt reset", 16'h1, {15'h0, cpu_rst});
        wait_rel(64, 70);
        rd_cause(4'b0010);
        wd_sel = 1'b0;
        wdt_to = 1'b1;
        step(1);
        chk("wdt irq", 16'h1, {15'h0, wdt_irq});
        wdt_to = 1'b0;
        step(3);
        chk("no wdt reset", 16'h0, {15'h0, cpu_rst});
        wd_sel = 1'b1;
        // stop mode: options, disabled pin, then enabled pin edge
        stop_mode = 1'b1;
        bo_stop = 1'b0;
        step(2);
        chk("bo off in stop", 16'h0, {15'h0, bo_act});
        chk("port in off", 16'h0, {15'h0, pin_en});
        bo_stop = 1'b1;
        gpio_in = 8'h02;
        step(4);
        chk("bo on in stop", 16'h1, {15'h0, bo_act});
        chk("disabled pin", 16'h0, {15'h0, cpu_rst});
        gpio_in = 8'h03;
        step(2);
        chk("gpio recovery", 16'h1, {15'h0, cpu_rst});
        chk("ctl kept", 16'h0, {15'h0, ctl_rst});
        chk("port data frozen", 16'h0000, {8'h0, pdata});
        chk("wdt osc reset", 16'h1, {15'h0, wo_rst});
        stop_mode = 1'b0;
        wait_rel(64, 70);
        chk("ipo selected", 16'h1, {15'h0, osc_sel});
        rd_cause(4'b0100);
        chk("port data captured", 16'h0003, {8'h0, pdata});
        stop_mode = 1'b1;
        wdt_pulse();
        chk("wdt recovery", 16'h1, {15'h0, cpu_rst});
        stop_mode = 1'b0;
        wait_rel(64, 70);
        rd_cause(4'b0110);
        stop_mode = 1'b1;
        dbg_pin = 1'b0;
        step(3);
        dbg_pin = 1'b1;
        stop_mode = 1'b0;
        chk("debug pin reset", 16'h1, {15'h0, ctl_rst});
        wait_rel(64, 70);
        rd_cause(4'b1000);
        // debugger reset with the long crystal delay
        xtal_en = 1'b1;
        dbg_set = 1'b1;
        step(1);
        dbg_set = 1'b0;
        step(2);
        chk("dbg reset", 16'h1, {15'h0, sys_rst});
        chk("dbg clear", 16'h1, {15'h0, dbg_clr});
        wait_rel(4995, 5005);
        rd_cause(4'b1000);
        xtal_en = 1'b0;
        // brown-out holds reset for as long as it lasts
        bo_low = 1'b1;
        step(300);
        chk("bo hold", 16'h1, {15'h0, sys_rst});
        bo_low = 1'b0;
        step(2);
        wait_rel(64, 70);
        rd_cause(4'b1000);
        lvd_low = 1'b1;
        step(2);
        chk("lvd live", 16'h1, {15'h0, cause[0]});
        chk("lvd irq", 16'h1, {15'h0, lvd_irq});
        rd_cause(4'b0000);
        chk("lvd after read", 16'h1, {15'h0, cause[0]});
        bo_en = 1'b0;
        step(2);
        chk("lvd off", 16'h0, {15'h0, cause[0]});
        lvd_low = 1'b0;
        bo_en = 1'b1;
        step(2);
        chk("lvd gone", 16'h0, {15'h0, cause[0]});
        end_sim();
    end
endmodule
